// ===== apfio_top.sv
// What this block does
// - Each shared analog pin can act as a flag-bus bit, pin 0 as bit 10 and pin 1 as bit 11, chosen by route and direction registers.
// - A pin set as digital input has its output buffer released at once.
// - Route 0 with source 0 gives an analog output, buffer off with enable 0 and on with enable 1.
// - Route 1, direction 1, source 1 and I/O control 0 give a digital input with the buffer off.
// - Route 1, direction 0, source 1 and I/O control 1 give a digital output with the buffer driving.
// - The source bit selects analog at 0 (reset) and the pin's flag drive signal at 1.
// - Source, enable and I/O control reset to 0, leaving both pins analog and undriven.
// - With digital output selected the internal flag line is an output (direction 0) and the analog path is cut.
// - The pin level does not follow the I/O supply; the digital output runs through the 5 V amplifier.
// - A weak pull-down stays on each pin in every mode.
// - With source 0, amplifier enable 0 forces the pin off whatever the analog source select holds.
`timescale 1ns/1ps
`default_nettype none
module apfio_top (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	// SPI register port, one word per strobe
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [9:0]  i_reg_addr,
	input  wire logic [15:0] i_reg_wdata,
	output logic [15:0]      o_reg_rdata,
	output logic             o_reg_rvalid,
	// Flag bus from microcores
	input  wire logic [1:0]  i_pin_flag_drive,
	output logic [15:0]      o_flag_in,
	output logic [15:0]      o_flag_in_valid,
	// Shared analog pins
	input  wire logic [1:0]  i_shared_analog_pin,
	output logic [1:0]       o_shared_analog_pin,
	output logic [1:0]       o_shared_analog_pin_oe,
	output logic [1:0]       o_shared_analog_pin_pulldown,
	// Analog amplifier control
	output logic [1:0]       o_amp_path_enable,
	output logic [5:0]       o_amp_source_sel,
	output logic [3:0]       o_amp_gain,
	output logic             o_amp_supply_5v
);
	logic [15:0] flag_dir_q;
	logic [15:0] flag_route_q;
	logic [15:0] pin_cfg_q;
	logic [15:0] rdata_q;
	logic        rvalid_q;
	logic [1:0]  flag_in;
	logic [1:0]  flag_in_valid;

	// Register writes
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			flag_dir_q   <= apfio_pkg::FLAG_DIRECTION_RESET;
			flag_route_q <= apfio_pkg::FLAG_ROUTE_RESET;
			pin_cfg_q    <= apfio_pkg::PIN_CONFIG_RESET;
		end else if (i_reg_wr) begin
			if (i_reg_addr == apfio_pkg::FLAG_DIRECTION_CTRL_ADDR) begin
				flag_dir_q <= i_reg_wdata;
			end else if (i_reg_addr == apfio_pkg::FLAG_ROUTE_SELECT_ADDR) begin
				flag_route_q <= i_reg_wdata;
			end else if (i_reg_addr == apfio_pkg::PIN_CONFIG_ADDR) begin
				pin_cfg_q <= i_reg_wdata;
			end
		end
	end

	// Register reads; unmapped words read zero
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_q  <= 16'h0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= i_reg_rd;
			if (!i_reg_rd) begin
				rdata_q <= rdata_q;
			end else if (i_reg_addr == apfio_pkg::FLAG_DIRECTION_CTRL_ADDR) begin
				rdata_q <= flag_dir_q;
			end else if (i_reg_addr == apfio_pkg::FLAG_ROUTE_SELECT_ADDR) begin
				rdata_q <= flag_route_q;
			end else if (i_reg_addr == apfio_pkg::PIN_CONFIG_ADDR) begin
				rdata_q <= pin_cfg_q;
			end else begin
				rdata_q <= 16'h0000;
			end
		end
	end
	assign o_reg_rdata  = rdata_q;
	assign o_reg_rvalid = rvalid_q;

	localparam int FB [2] = '{apfio_pkg::PIN0_FLAG_BIT, apfio_pkg::PIN1_FLAG_BIT};

	// One controller per shared pin
	for (genvar g = 0; g < 2; g++) begin : g_pin
		localparam int B = g * apfio_pkg::CFG_PIN_STRIDE;
		apfio_pin_ctrl apfio_pin_ctrl_inst (
			.i_sys_clk        (i_sys_clk),
			.i_reset_n        (i_reset_n),
			.i_route          (flag_route_q[FB[g]]),
			.i_dir_in         (flag_dir_q[FB[g]]),
			.i_source         (pin_cfg_q[B + apfio_pkg::CFG_SOURCE_POS]),
			.i_amp_enable     (pin_cfg_q[B + apfio_pkg::CFG_ENABLE_POS]),
			.i_ioctrl         (pin_cfg_q[B + apfio_pkg::CFG_IOCTRL_POS]),
			.i_pin_flag_drive (i_pin_flag_drive[g]),
			.i_pad_in         (i_shared_analog_pin[g]),
			.o_pad_out        (o_shared_analog_pin[g]),
			.o_pad_oe         (o_shared_analog_pin_oe[g]),
			.o_analog_path_en (o_amp_path_enable[g]),
			.o_flag_in        (flag_in[g]),
			.o_flag_in_valid  (flag_in_valid[g]),
			.o_mode           ()
		);
		assign o_amp_source_sel[g*3 +: 3] = pin_cfg_q[B + apfio_pkg::CFG_ANSEL_POS +: 3];
		// Gain code also sets the digital level: 00 gives 3.3 V, 01 gives 5.0 V
		assign o_amp_gain[g*2 +: 2] = pin_cfg_q[B + apfio_pkg::CFG_GAIN_POS +: 2];
	end

	// Flag-bus view: only bits 10 and 11 belong to this block
	always_comb begin
		o_flag_in       = 16'h0000;
		o_flag_in_valid = 16'h0000;
		o_flag_in[apfio_pkg::PIN0_FLAG_BIT]       = flag_in[0] & flag_in_valid[0];
		o_flag_in[apfio_pkg::PIN1_FLAG_BIT]       = flag_in[1] & flag_in_valid[1];
		o_flag_in_valid[apfio_pkg::PIN0_FLAG_BIT] = flag_in_valid[0];
		o_flag_in_valid[apfio_pkg::PIN1_FLAG_BIT] = flag_in_valid[1];
	end

	// Amplifier always on the 5 V rail, never the I/O supply
	assign o_amp_supply_5v              = 1'b1;
	// Pull-down held in every mode
	assign o_shared_analog_pin_pulldown = 2'b11;
endmodule : apfio_top
`default_nettype wire

// ===== apfio_pkg.sv
`default_nettype none
package apfio_pkg;

	// Register word addresses on the SPI register port
	localparam logic [9:0]  FLAG_DIRECTION_CTRL_ADDR = 10'h1c1;
	localparam logic [9:0]  FLAG_ROUTE_SELECT_ADDR   = 10'h1c3;
	localparam logic [9:0]  PIN_CONFIG_ADDR          = 10'h1a8;

	// Register reset values
	localparam logic [15:0] FLAG_DIRECTION_RESET     = 16'h0000;
	localparam logic [15:0] FLAG_ROUTE_RESET         = 16'h0000;
	localparam logic [15:0] PIN_CONFIG_RESET         = 16'h0000;

	// Flag-bus bit positions of the two shared pins
	localparam int          PIN0_FLAG_BIT            = 10;
	localparam int          PIN1_FLAG_BIT            = 11;

	// Per-pin config field layout: pin x uses base 8*x
	localparam int          CFG_SOURCE_POS           = 0;
	localparam int          CFG_ENABLE_POS           = 1;
	localparam int          CFG_IOCTRL_POS           = 2;
	localparam int          CFG_GAIN_POS             = 3;
	localparam int          CFG_ANSEL_POS            = 5;
	localparam int          CFG_PIN_STRIDE           = 8;

	// Gain codes meant for digital use
	localparam logic [1:0]  GAIN_IO_3V3              = 2'h0;
	localparam logic [1:0]  GAIN_IO_5V0              = 2'h1;

	typedef enum logic [3:0] {
		APFIO_MODE_ANALOG_OFF = 4'b0001,
		APFIO_MODE_ANALOG_ON  = 4'b0010,
		APFIO_MODE_DIG_IN     = 4'b0100,
		APFIO_MODE_DIG_OUT    = 4'b1000
	} apfio_mode_t;

endpackage : apfio_pkg
`default_nettype wire

// ===== apfio_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module apfio_sync2 (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_reset_n,
	// Level in and out
	input  wire logic i_level,
	output logic      o_level
);
	logic meta_q;
	logic sync_q;

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= i_level;
			sync_q <= meta_q;
		end
	end

	assign o_level = sync_q;
endmodule : apfio_sync2
`default_nettype wire

// ===== apfio_pin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module apfio_pin_ctrl (
	// Clock and reset
	input  wire logic               i_sys_clk,
	input  wire logic               i_reset_n,
	// Configuration
	input  wire logic               i_route,
	input  wire logic               i_dir_in,
	input  wire logic               i_source,
	input  wire logic               i_amp_enable,
	input  wire logic               i_ioctrl,
	// Flag bus side
	input  wire logic               i_pin_flag_drive,
	// Pad side
	input  wire logic               i_pad_in,
	output logic                    o_pad_out,
	output logic                    o_pad_oe,
	output logic                    o_analog_path_en,
	output logic                    o_flag_in,
	output logic                    o_flag_in_valid,
	output apfio_pkg::apfio_mode_t  o_mode
);
	apfio_pkg::apfio_mode_t mode;
	logic                   out_q;

	// Mode decode; any combination off the table leaves the buffer off
	always_comb begin
		if (!i_source) begin
			// Analog function; enable low forces HiZ whatever the source select
			mode = i_amp_enable ? apfio_pkg::APFIO_MODE_ANALOG_ON : apfio_pkg::APFIO_MODE_ANALOG_OFF;
		end else if (i_route && i_dir_in && !i_ioctrl) begin
			mode = apfio_pkg::APFIO_MODE_DIG_IN;
		end else if (i_route && !i_dir_in && i_ioctrl) begin
			mode = apfio_pkg::APFIO_MODE_DIG_OUT;
		end else begin
			mode = apfio_pkg::APFIO_MODE_ANALOG_OFF;
		end
	end

	// Pad level comes from outside the clock domain
	apfio_sync2 apfio_sync2_inst (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_level   (i_pad_in),
		.o_level   (o_flag_in)
	);

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			out_q <= 1'b0;
		end else begin
			out_q <= i_pin_flag_drive;
		end
	end

	// Input mode drops the driver at once, no register in the path
	assign o_pad_oe         = (mode == apfio_pkg::APFIO_MODE_DIG_OUT);
	assign o_pad_out        = out_q;
	// Digital output mutes the analog path
	assign o_analog_path_en = (mode == apfio_pkg::APFIO_MODE_ANALOG_ON);
	assign o_flag_in_valid  = (mode == apfio_pkg::APFIO_MODE_DIG_IN);
	assign o_mode           = mode;
endmodule : apfio_pin_ctrl
`default_nettype wire

// ===== apfio_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module apfio_top_props (
	// Clock and reset
	input wire logic        i_sys_clk,
	input wire logic        i_reset_n,
	// Watched ports
	input wire logic [1:0]  i_shared_analog_pin,
	input wire logic [1:0]  i_pin_flag_drive,
	input wire logic        i_reg_rd,
	input wire logic        o_reg_rvalid,
	input wire logic [15:0] o_flag_in,
	input wire logic [15:0] o_flag_in_valid,
	input wire logic [1:0]  o_shared_analog_pin,
	input wire logic [1:0]  o_shared_analog_pin_oe,
	input wire logic [1:0]  o_shared_analog_pin_pulldown,
	input wire logic [1:0]  o_amp_path_enable,
	input wire logic        o_amp_supply_5v
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	property p_pd; o_shared_analog_pin_pulldown == 2'h3; endproperty
	a_pd: assert property (p_pd) else $error("pulldown off");
	property p_sup; o_amp_supply_5v; endproperty
	a_sup: assert property (p_sup) else $error("supply not 5v");
	property p_cut; (o_shared_analog_pin_oe & o_amp_path_enable) == 2'h0; endproperty
	a_cut: assert property (p_cut) else $error("analog path with digital drive");
	property p_drv; o_shared_analog_pin_oe[0] |-> o_shared_analog_pin[0] == $past(i_pin_flag_drive[0]); endproperty
	a_drv: assert property (p_drv) else $error("pin drive wrong");
	property p_in; o_flag_in_valid[11] && $past(o_flag_in_valid[11], 2) |-> o_flag_in[11] == $past(i_shared_analog_pin[1], 2);
	endproperty
	a_in: assert property (p_in) else $error("flag input wrong");
	property p_hiz; (o_flag_in_valid[11:10] & o_shared_analog_pin_oe) == 2'h0; endproperty
	a_hiz: assert property (p_hiz) else $error("input pin driven");
	property p_map; (o_flag_in & 16'hf3ff) == 16'h0 && (o_flag_in_valid & 16'hf3ff) == 16'h0; endproperty
	a_map: assert property (p_map) else $error("flag bit map wrong");
	property p_rst; $rose(i_reset_n) |-> o_shared_analog_pin_oe == 2'h0 && o_amp_path_enable == 2'h0; endproperty
	a_rst: assert property (p_rst) else $error("pins active after reset");
	property p_rv; i_reg_rd |=> o_reg_rvalid ##1 !o_reg_rvalid || $past(i_reg_rd); endproperty
	a_rv: assert property (p_rv) else $error("read answer timing");
	c_out: cover property (o_shared_analog_pin_oe[0]);
	c_in: cover property (o_flag_in_valid[11] && o_flag_in[11]);
	c_ana: cover property (o_amp_path_enable[0]);
endmodule : apfio_top_props
bind apfio_top apfio_top_props apfio_top_props_inst (.*);
`default_nettype wire

// ===== apfio_mcu_pin.sv
`timescale 1ns/1ps
`default_nettype none
module apfio_mcu_pin (
	// Device side
	input wire logic [1:0]  i_dev_oe,
	input wire logic [1:0]  i_dev_out,
	// Controller pin
	input wire logic [1:0]  i_mcu_oe,
	input wire logic [1:0]  i_mcu_val,
	output logic [1:0]      o_pad
);
	// Undriven pad settles low through the weak pull-down
	assign o_pad = (i_dev_oe & i_dev_out) | (~i_dev_oe & i_mcu_oe & i_mcu_val);
endmodule : apfio_mcu_pin
`default_nettype wire

// ===== apfio_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module apfio_top_test;
	logic i_sys_clk = 0, i_reset_n = 0, wr = 0, rd = 0;
	logic [9:0] addr = 0;
	logic [15:0] wd = 0, rdat, fin, fv;
	logic [1:0] drv = 0, moe = 0, mval = 0, pad, pout, poe, pd, apath;
	logic [5:0] asel;
	logic [3:0] gain;
	logic rv, s5;
	int error_cnt = 0, samples_checked = 0, cyc = 0;
	always #5 i_sys_clk = ~i_sys_clk;
	apfio_top apfio_top_inst (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_reg_wr(wr), .i_reg_rd(rd),
		.i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_reg_rvalid(rv), .i_pin_flag_drive(drv),
		.o_flag_in(fin), .o_flag_in_valid(fv), .i_shared_analog_pin(pad), .o_shared_analog_pin(pout),
		.o_shared_analog_pin_oe(poe), .o_shared_analog_pin_pulldown(pd), .o_amp_path_enable(apath),
		.o_amp_source_sel(asel), .o_amp_gain(gain), .o_amp_supply_5v(s5));
	apfio_mcu_pin apfio_mcu_pin_inst (.i_dev_oe(poe), .i_dev_out(pout), .i_mcu_oe(moe), .i_mcu_val(mval), .o_pad(pad));
	task automatic final_report;
		if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : final_report
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (e !== g) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic cyc_n(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask : cyc_n
	task automatic wrr(input logic [9:0] a, input logic [15:0] d);
		addr = a; wd = d; wr = 1;
		cyc_n(1);
		wr = 0;
		// Idle edge so a following call never re-raises the strobe in the same step
		cyc_n(1);
	endtask : wrr
	task automatic rdc(input logic [9:0] a, input logic [15:0] e);
		addr = a; rd = 1;
		cyc_n(1);
		rd = 0;
		chk("rvalid", 16'h1, rv);
		chk("rdata", e, rdat);
		cyc_n(1);
	endtask : rdc
	task automatic t_reset;
		rdc(apfio_pkg::FLAG_ROUTE_SELECT_ADDR, apfio_pkg::FLAG_ROUTE_RESET);
		rdc(apfio_pkg::FLAG_DIRECTION_CTRL_ADDR, apfio_pkg::FLAG_DIRECTION_RESET);
		rdc(apfio_pkg::PIN_CONFIG_ADDR, apfio_pkg::PIN_CONFIG_RESET);
		chk("oe", 16'h0, poe);
		chk("pulldown", 16'h3, pd);
		chk("supply", 16'h1, s5);
	endtask : t_reset
	task automatic t_analog;
		wrr(apfio_pkg::PIN_CONFIG_ADDR, 16'ha00a);
		rdc(apfio_pkg::PIN_CONFIG_ADDR, 16'ha00a);
		rdc(10'h000, 16'h0);
		chk("amp", 16'h1, apath);
		chk("oe", 16'h0, poe);
		chk("gain", 16'h1, gain);
		chk("asel", 16'h28, asel);
	endtask : t_analog
	task automatic t_digital;
		wrr(apfio_pkg::FLAG_ROUTE_SELECT_ADDR, 16'h0c00);
		wrr(apfio_pkg::FLAG_DIRECTION_CTRL_ADDR, 16'h0800);
		wrr(apfio_pkg::PIN_CONFIG_ADDR, 16'h0107);
		chk("oe", 16'h1, poe);
		chk("amp", 16'h0, apath);
		chk("valid", 16'h0800, fv);
		drv = 2'h1; moe = 2'h2; mval = 2'h2;
		cyc_n(3);
		chk("pad", 16'h3, pad);
		chk("flag_in", 16'h0800, fin);
		drv = 2'h0; mval = 2'h0;
		cyc_n(3);
		chk("pad", 16'h0, pad);
		chk("flag_in", 16'h0, fin);
	endtask : t_digital
	task automatic t_rst_mid;
		i_reset_n = 0;
		#1;
		chk("oe", 16'h0, poe);
		chk("amp", 16'h0, apath);
		chk("valid", 16'h0, fv);
		cyc_n(2);
		i_reset_n = 1;
		t_reset();
	endtask : t_rst_mid
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		cyc_n(4);
		i_reset_n = 1;
		t_reset();
		t_analog();
		t_digital();
		t_rst_mid();
		final_report();
	end
endmodule : apfio_top_test
`default_nettype wire
